// >>> membus_cycle_port.sv
// processor-side memory bus cycle controller
// assumes memory pulses arrive through a pin synchroniser on CLOCK
`timescale 1ns/10ps
module membus_cycle_port #(
    parameter int TIMEOUT_CYCLES = membus_pkg::TIMEOUT_CYC
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic CLOCK_EN,
    input wire logic POWER_OK,
    input wire logic USE_MUX,
    // user side
    input wire logic START_READ,
    input wire logic START_WRITE,
    input wire logic [membus_pkg::ADDR_W-1:0] START_ADDR,
    input wire logic [membus_pkg::DATA_W-1:0] WRITE_DATA,
    input wire logic MODIFY_DONE,
    input wire logic [membus_pkg::DATA_W-1:0] MODIFY_DATA,
    output logic BUSY,
    output logic [membus_pkg::DATA_W-1:0] READ_DATA,
    output logic READ_VALID,
    output logic MODIFY_WAIT,
    output logic DONE,
    output logic NXM_ERROR,
    output logic PARITY_ERROR,
    // bus side
    output membus_pkg::request_s BUS_REQ,
    output logic MUX_PORT_CLAIM,
    input wire logic MUX_PORT_GRANT,
    output logic MUX_CLEAR_PULSE,
    input wire logic ADDR_ACK_PULSE,
    input wire logic PARITY_ABSENT_PULSE,
    input wire logic READ_RESTART_PULSE,
    output logic WRITE_RESTART_PULSE,
    input wire logic [membus_pkg::DATA_W-1:0] BUS_DATA_LINES_IN,
    input wire logic BUS_PARITY_IN,
    output logic [membus_pkg::DATA_W-1:0] BUS_DATA_LINES_OUT,
    output logic BUS_PARITY_OUT,
    output logic BUS_DATA_OE,
    output logic RECEIVE_EN
);

    typedef enum logic [3:0] {
        IDLE, SETUP, CLAIM, REQUEST, READ_WAIT, MODIFY, SEND, RESTART, FINISH
    } state_e;

    localparam int PW = membus_pkg::DATA_W + 1;

    // odd parity over a data word
    function automatic logic odd_par(input logic [membus_pkg::DATA_W-1:0] d);
        odd_par = ~(^d);
    endfunction : odd_par

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // three stages; a change counts once stages two and three agree
    logic [PW+3:0] s1_reg, s2_reg, s3_reg, pin_reg;
    logic [PW+3:0] pin_raw;
    // data above parity, so the low word lines up with word_s {data, parity}
    assign pin_raw = {MUX_PORT_GRANT, ADDR_ACK_PULSE, PARITY_ABSENT_PULSE,
                      READ_RESTART_PULSE, BUS_DATA_LINES_IN, BUS_PARITY_IN};
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            pin_reg <= '0;
        end else if (CLOCK_EN) begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < PW + 4; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    pin_reg[i] <= s3_reg[i];
                end
            end
        end
    end

    logic grant_ok, ack_p, nopar_p, rdrs_p;
    logic [PW-1:0] pin_word;
    assign grant_ok = pin_reg[PW+3] | ~USE_MUX; // direct bus: grant tied true
    assign ack_p = pin_reg[PW+2];
    assign nopar_p = pin_reg[PW+1];
    assign rdrs_p = pin_reg[PW];
    assign pin_word = pin_reg[PW-1:0];

    // ----------------------------------------------------------------
    // cycle control
    // ----------------------------------------------------------------
    state_e state_reg;
    logic rd_type_reg, wr_type_reg;
    logic [membus_pkg::ADDR_W-1:0] addr_reg;
    logic req_reg;
    logic [1:0] pulse_cnt_reg;
    logic [$clog2(membus_pkg::TIMEOUT_CYC+1):0] to_cnt_reg;
    logic nopar_reg;
    membus_pkg::word_s cap_reg;
    membus_pkg::word_s out_reg;
    logic wrrs_reg, mpxclr_reg, oe_reg;
    logic start_any;
    logic timed_out;

    assign start_any = START_READ | START_WRITE;
    assign timed_out = (to_cnt_reg >= TIMEOUT_CYCLES[$bits(to_cnt_reg)-1:0]);

    // state sequencing; errors return to idle so memory is never left hung
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state_reg <= IDLE;
        end else if (CLOCK_EN) begin
            case (state_reg)
                IDLE: if (start_any && POWER_OK) state_reg <= SETUP;
                SETUP: if (pulse_cnt_reg == 2'(membus_pkg::TYPE_PULSE_CYC)) begin
                    state_reg <= USE_MUX ? CLAIM : REQUEST;
                end
                CLAIM: if (grant_ok) state_reg <= REQUEST;
                REQUEST: begin
                    if (ack_p) begin
                        state_reg <= rd_type_reg ? READ_WAIT : SEND;
                    end else if (timed_out) begin
                        state_reg <= FINISH;
                    end
                end
                READ_WAIT: begin
                    if (rdrs_p) begin
                        state_reg <= wr_type_reg ? MODIFY : FINISH;
                    end else if (timed_out) begin
                        state_reg <= FINISH;
                    end
                end
                MODIFY: if (MODIFY_DONE) state_reg <= SEND;
                SEND: state_reg <= RESTART;
                RESTART: state_reg <= FINISH;
                FINISH: state_reg <= IDLE;
                default: state_reg <= IDLE;
            endcase
        end
    end

    // cycle type register set from start strobes held a 40 ns width
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            rd_type_reg <= 1'b0;
            wr_type_reg <= 1'b0;
            addr_reg <= '0;
            pulse_cnt_reg <= '0;
        end else if (CLOCK_EN) begin
            if (state_reg == IDLE && start_any && POWER_OK) begin
                rd_type_reg <= START_READ;
                wr_type_reg <= START_WRITE;
                addr_reg <= START_ADDR;
                pulse_cnt_reg <= '0;
            end else if (state_reg == SETUP) begin
                pulse_cnt_reg <= pulse_cnt_reg + 2'd1;
            end
        end
    end

    // cycle request: only once lines have settled, dropped on acknowledge
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            req_reg <= 1'b0;
        end else if (CLOCK_EN) begin
            req_reg <= (state_reg == REQUEST) && !ack_p && !timed_out
                       && POWER_OK && grant_ok;
        end
    end

    // 100 us watchdog from request and through the read phase
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            to_cnt_reg <= '0;
        end else if (CLOCK_EN) begin
            if (state_reg == REQUEST || state_reg == READ_WAIT) begin
                if (!timed_out) to_cnt_reg <= to_cnt_reg + 1'b1;
            end else begin
                to_cnt_reg <= '0;
            end
        end
    end

    // read capture: cleared in setup, pulses only set bits
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            cap_reg <= '0;
            nopar_reg <= 1'b0;
        end else if (CLOCK_EN) begin
            if (state_reg == SETUP) begin
                cap_reg <= '0;
                nopar_reg <= 1'b0;
            end else if (state_reg == REQUEST || state_reg == READ_WAIT) begin
                if (rd_type_reg) cap_reg <= cap_reg | pin_word;
                if (nopar_p) nopar_reg <= 1'b1;
            end
        end
    end

    // write word, one strobe of data then a write restart strobe
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            out_reg <= '0;
            oe_reg <= 1'b0;
            wrrs_reg <= 1'b0;
        end else if (CLOCK_EN) begin
            oe_reg <= (state_reg == SEND) && grant_ok && POWER_OK;
            wrrs_reg <= (state_reg == RESTART) && grant_ok && POWER_OK;
            if (state_reg == SEND) begin
                out_reg.data <= rd_type_reg ? MODIFY_DATA : WRITE_DATA;
                out_reg.parity <= odd_par(rd_type_reg ? MODIFY_DATA : WRITE_DATA);
            end else begin
                out_reg <= '0; // no pulse means zero
            end
        end
    end

    // user results and multiplexor clear on nonexistent memory
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            READ_DATA <= '0;
            READ_VALID <= 1'b0;
            DONE <= 1'b0;
            NXM_ERROR <= 1'b0;
            PARITY_ERROR <= 1'b0;
            mpxclr_reg <= 1'b0;
        end else if (CLOCK_EN) begin
            READ_VALID <= 1'b0;
            DONE <= 1'b0;
            mpxclr_reg <= 1'b0;
            if (state_reg == READ_WAIT && rdrs_p) begin
                READ_DATA <= cap_reg.data | pin_word[PW-1:1];
                READ_VALID <= 1'b1;
                PARITY_ERROR <= !nopar_reg && !nopar_p
                    && (odd_par(cap_reg.data | pin_word[PW-1:1])
                        != (cap_reg.parity | pin_word[0]));
            end
            if (timed_out && (state_reg == REQUEST || state_reg == READ_WAIT)) begin
                NXM_ERROR <= 1'b1;
                mpxclr_reg <= USE_MUX && POWER_OK;
            end
            if (state_reg == FINISH) DONE <= 1'b1;
            if (state_reg == IDLE && start_any) begin
                NXM_ERROR <= 1'b0;
                PARITY_ERROR <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // receivers off while sending and while not granted
    assign RECEIVE_EN = grant_ok && !oe_reg
                        && (state_reg == REQUEST || state_reg == READ_WAIT);
    assign BUS_REQ.cycle_request_level = req_reg && POWER_OK;
    assign BUS_REQ.read_type_line = rd_type_reg && grant_ok && state_reg != IDLE;
    assign BUS_REQ.write_type_line = wr_type_reg && grant_ok && state_reg != IDLE;
    assign BUS_REQ.memory_address_lines = grant_ok ? addr_reg : '0;
    assign MUX_PORT_CLAIM = USE_MUX && POWER_OK
                            && state_reg != IDLE && state_reg != FINISH;
    assign MUX_CLEAR_PULSE = mpxclr_reg;
    assign WRITE_RESTART_PULSE = wrrs_reg;
    assign BUS_DATA_LINES_OUT = out_reg.data;
    assign BUS_PARITY_OUT = out_reg.parity;
    assign BUS_DATA_OE = oe_reg;
    assign BUSY = state_reg != IDLE;
    assign MODIFY_WAIT = state_reg == MODIFY;

endmodule : membus_cycle_port

// >>> membus_pkg.sv
// package for the memory bus cycle controller (processor end)
// assumes one 50 MHz clock; pulses sent are one-cycle strobes, pulses received stand several cycles
// Contract
// - processor sends write restart after write data
// - data lines are two-way
// - pulse means one, none means zero
// - receiver clears capture before data arrives
// - processor sends odd parity pulse
// - processor receivers disabled while transmitting
// - peripheral claims multiplexor by level
// - all lines disabled until grant
// - send multiplexor clear on nonexistent memory
// - time 100 us for address acknowledge
// - cycle request forced off during power transitions
// - no spurious pulses during power transitions
// - at most sixteen modules per bus
// - drop request on acknowledge, read then restart
// - write sends data, parity, then write restart
// - read-modify-write does read then write
// - start pulses set cycle type register
// - recover from errors without hanging memory
// - two type lines encode cycle kind
// - request false while address or type change
package membus_pkg;

    // ----------------------------------------------------------------
    // widths and timing
    // ----------------------------------------------------------------
    localparam int DATA_W = 36;
    localparam int ADDR_W = 18;
    localparam int CLK_MHZ = 50;
    localparam int TIMEOUT_US = 100;
    localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
    localparam int TYPE_PULSE_NS = 40;
    localparam int CLK_NS = 20;
    localparam int TYPE_PULSE_CYC = (TYPE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_CYC = 1;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic parity;
    } word_s;

    typedef struct packed {
        logic read_type_line;
        logic write_type_line;
        logic cycle_request_level;
        logic [ADDR_W-1:0] memory_address_lines;
    } request_s;

endpackage : membus_pkg

// >>> membus_memory_model.sv
// memory module model on the far side of the bus, one cycle at a time
// assumes the port needs each pulse to stand 2 clocks for its synchroniser
`timescale 1ns/10ps
module membus_memory_model #(parameter int FAULT_CYC = 200, parameter bit RECOVER = 1'b1) (
    input wire logic clk, input wire logic rst, input wire logic present,
    input wire logic no_parity, input wire logic slow, input wire membus_pkg::request_s req,
    input wire logic oe, input wire logic [35:0] dout, input wire logic pout,
    input wire logic write_restart_pulse, output logic ack = 1'b0, output logic pabs = 1'b0,
    output logic read_restart_pulse = 1'b0, output logic [35:0] din = 36'h0, output logic pin = 1'b0
);
    membus_pkg::word_s mem [16];
    membus_pkg::word_s cap;
    logic [3:0] a;
    logic rd, wr;
    int n;
    // act just after the edge, once the port's registers have settled
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    // ----
    // cycle
    // ----
    always begin
        tick();
        if (!rst && present && req.cycle_request_level) begin
            a = req.memory_address_lines[3:0];
            {rd, wr} = {req.read_type_line, req.write_type_line};
            cap = '0;
            if (slow) repeat (8) tick();
            ack <= 1'b1;
            pabs <= no_parity;
            repeat (3) tick();
            {ack, pabs} <= 2'h0;
            if (rd) begin
                din <= mem[a].data;
                pin <= mem[a].parity & !no_parity;
                tick();
                read_restart_pulse <= 1'b1;
                repeat (4) tick();
                read_restart_pulse <= 1'b0;
                tick();
                {din, pin} <= 37'h0;
            end
            // give up on a write that never gets its restart
            for (n = 0; wr && n < FAULT_CYC && !write_restart_pulse; n++) begin
                tick();
                if (oe) cap = cap | {dout, pout};
            end
            if (wr && write_restart_pulse) mem[a] = cap;
            while (wr && !write_restart_pulse && !RECOVER && !rst) tick();
            while (req.cycle_request_level && !rst) tick();
        end
    end
endmodule : membus_memory_model

// >>> membus_cycle_port_properties.sv
// assertions on the processor end of the memory bus
// assumes membus_pkg is compiled first; bound into membus_cycle_port below
`timescale 1ns/10ps
module membus_cycle_port_properties #(parameter int TIMEOUT_CYCLES = membus_pkg::TIMEOUT_CYC) (
    input wire logic CLOCK, input wire logic RESET, input wire logic POWER_OK,
    input wire logic ADDR_ACK_PULSE, input wire membus_pkg::request_s BUS_REQ,
    input wire logic WRITE_RESTART_PULSE, input wire logic [35:0] BUS_DATA_LINES_OUT,
    input wire logic BUS_PARITY_OUT, input wire logic BUS_DATA_OE, input wire logic RECEIVE_EN
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);
    wire logic req = BUS_REQ.cycle_request_level;
    int req_cnt;
    // request age; a counter since the timeout is far past a delay range
    always_ff @(posedge CLOCK) req_cnt <= (RESET || !req) ? 0 : req_cnt + 1;
    // ----
    // properties
    // ----
    sequence s_ack_taken;
        $rose(ADDR_ACK_PULSE) ##0 req;
    endsequence
    property p_power; !POWER_OK |-> !req && !WRITE_RESTART_PULSE; endproperty
    a_power: assert property (p_power) else $error("bus active, supplies down");
    property p_rx_off; BUS_DATA_OE |-> !RECEIVE_EN; endproperty
    a_rx_off: assert property (p_rx_off) else $error("receivers on while sending");
    property p_parity; BUS_DATA_OE |-> BUS_PARITY_OUT == ~^BUS_DATA_LINES_OUT; endproperty
    a_parity: assert property (p_parity) else $error("parity not odd");
    property p_wrs; WRITE_RESTART_PULSE |-> $past(BUS_DATA_OE); endproperty
    a_wrs: assert property (p_wrs) else $error("restart without data");
    property p_stable; req && $past(req) |-> $stable(BUS_REQ); endproperty
    a_stable: assert property (p_stable) else $error("request lines moved");
    property p_types; $rose(req) |-> BUS_REQ.read_type_line || BUS_REQ.write_type_line; endproperty
    a_types: assert property (p_types) else $error("request with no cycle type");
    property p_drop; s_ack_taken |-> ##[1:8] !req; endproperty
    a_drop: assert property (p_drop) else $error("request held after ack");
    property p_timeout; req_cnt <= TIMEOUT_CYCLES + 8; endproperty
    a_timeout: assert property (p_timeout) else $error("no timeout on request");
endmodule : membus_cycle_port_properties
bind membus_cycle_port membus_cycle_port_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (.*);

// >>> memory_bus_cycle_port_tb.sv
// self-checking bench for the processor end of the memory bus
// assumes the package, memory model and checker are compiled first
`timescale 1ns/10ps
module memory_bus_cycle_port_tb;
    logic CLOCK = 1'b0, RESET = 1'b1, CLOCK_EN = 1'b1, POWER_OK = 1'b1, USE_MUX = 1'b0;
    logic START_READ = 1'b0, START_WRITE = 1'b0, MODIFY_DONE = 1'b0, MUX_PORT_GRANT = 1'b0;
    logic [17:0] START_ADDR = 18'h0;
    logic [35:0] WRITE_DATA = 36'h0, MODIFY_DATA = 36'h0, got = 36'h0;
    logic BUSY, READ_VALID, MODIFY_WAIT, DONE, NXM_ERROR, PARITY_ERROR, MUX_PORT_CLAIM;
    logic MUX_CLEAR_PULSE, ADDR_ACK_PULSE, PARITY_ABSENT_PULSE, READ_RESTART_PULSE;
    logic WRITE_RESTART_PULSE, BUS_PARITY_IN, BUS_PARITY_OUT, BUS_DATA_OE, RECEIVE_EN;
    logic [35:0] READ_DATA, BUS_DATA_LINES_IN, BUS_DATA_LINES_OUT;
    membus_pkg::request_s BUS_REQ;
    logic present = 1'b1, no_parity = 1'b0, slow = 1'b0, cleared = 1'b0;
    int n_errors = 0, checks = 0;
    always #10 CLOCK = ~CLOCK;
    // an uncontended multiplexor grants what is claimed
    always @(negedge CLOCK) MUX_PORT_GRANT <= MUX_PORT_CLAIM;
    always @(posedge CLOCK) cleared <= cleared | (MUX_CLEAR_PULSE === 1'b1);
    membus_cycle_port #(.TIMEOUT_CYCLES(50)) dut (.*);
    membus_memory_model mem (.clk(CLOCK), .rst(RESET), .present, .no_parity, .slow,
        .req(BUS_REQ), .oe(BUS_DATA_OE), .dout(BUS_DATA_LINES_OUT), .pout(BUS_PARITY_OUT),
        .write_restart_pulse(WRITE_RESTART_PULSE), .ack(ADDR_ACK_PULSE), .pabs(PARITY_ABSENT_PULSE),
        .read_restart_pulse(READ_RESTART_PULSE), .din(BUS_DATA_LINES_IN), .pin(BUS_PARITY_IN));
    task automatic check(input logic [35:0] g, input logic [35:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic wrap_up;
        if (n_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // one cycle from the user side; the modify step is answered at once
    task automatic run(input logic rd, input logic wr, input logic [17:0] a,
        input logic [35:0] d);
        @(negedge CLOCK);
        {START_READ, START_WRITE, START_ADDR, WRITE_DATA, got} = {rd, wr, a, d, 36'h0};
        @(negedge CLOCK);
        {START_READ, START_WRITE} = 2'h0;
        for (int n = 0; n < 500 && DONE !== 1'b1; n++) begin
            @(negedge CLOCK);
            if (READ_VALID === 1'b1) got = READ_DATA;
            MODIFY_DONE = (MODIFY_WAIT === 1'b1) && !MODIFY_DONE;
        end
        check({35'h0, DONE}, 36'h1);
    endtask : run
    // ----
    // scenarios
    // ----
    // outer bits, back to back, then a modify that clears old bits
    task automatic t_data;
        MODIFY_DATA = 36'h7_ffff_fffe;
        run(1'b0, 1'b1, 18'h3, 36'h8_0000_0001);
        run(1'b1, 1'b0, 18'h3, 36'h0);
        check(got, 36'h8_0000_0001);
        check({35'h0, PARITY_ERROR}, 36'h0);
        run(1'b1, 1'b1, 18'h3, 36'h0);
        check(got, 36'h8_0000_0001);
        run(1'b1, 1'b0, 18'h3, 36'h0);
        check(got, 36'h7_ffff_fffe);
    endtask : t_data
    // missing memory through the multiplexor, then a slow module without parity
    task automatic t_mux;
        {USE_MUX, present} = 2'h2;
        run(1'b1, 1'b0, 18'h9, 36'h0);
        check({35'h0, NXM_ERROR}, 36'h1);
        check({35'h0, cleared}, 36'h1);
        {present, slow, no_parity} = 3'h7;
        run(1'b0, 1'b1, 18'h4, 36'h1_2345_6788);
        run(1'b1, 1'b0, 18'h4, 36'h0);
        check(got, 36'h1_2345_6788);
        check({34'h0, NXM_ERROR, PARITY_ERROR}, 36'h0);
        {slow, no_parity} = 2'h0;
    endtask : t_mux
    // a start while supplies are down is refused
    task automatic t_power;
        @(negedge CLOCK);
        {POWER_OK, START_READ} = 2'h1;
        @(negedge CLOCK);
        START_READ = 1'b0;
        repeat (10) @(negedge CLOCK);
        check({34'h0, BUSY, BUS_REQ.cycle_request_level}, 36'h0);
        POWER_OK = 1'b1;
    endtask : t_power
    initial begin
        repeat (20) @(posedge CLOCK);
        @(negedge CLOCK);
        RESET = 1'b0;
        t_data();
        t_mux();
        t_power();
        wrap_up();
    end
    // traffic needs well under 2000 cycles; a hang is cut off long after
    initial begin
        repeat (20000) @(posedge CLOCK);
        n_errors++;
        wrap_up();
    end
endmodule : memory_bus_cycle_port_tb
